// *** verilog/rmio_top.sv ***
// Remote discrete on/off, inhibit, trigger and status lines, per channel
`default_nettype none
module rmio_top
  import rmio_pkg::*;
#(
  parameter int NCH          = 3,
  parameter int PULSE_CYCLES = PULSE_CYC
)(
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  input  wire logic [NCH-1:0] enablePin,
  input  wire logic [NCH-1:0] inhibitClosedPin,
  input  wire logic [NCH-1:0] triggerPin,
  input  wire logic [NCH-1:0] ccMode,
  input  wire logic [NCH-1:0] faultState,
  output logic      [NCH-1:0] outputOn,
  output logic      [NCH-1:0] rampStart,
  output logic      [NCH-1:0] syncPulseOut,
  output logic      [NCH-1:0] regulation_mode_indicator,
  output logic      [NCH-1:0] outStateInd,
  output logic      [NCH-1:0] faultInd,
  output logic                irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NCH-1:0] enMeta;
  logic [NCH-1:0] enSync;
  logic [NCH-1:0] inhMeta;
  logic [NCH-1:0] inhSync;
  logic [NCH-1:0] trgMeta;
  logic [NCH-1:0] trgSync;
  logic [NCH-1:0] trgPrev;
  logic [NCH-1:0] next_enMeta;
  logic [NCH-1:0] next_enSync;
  logic [NCH-1:0] next_inhMeta;
  logic [NCH-1:0] next_inhSync;
  logic [NCH-1:0] next_trgMeta;
  logic [NCH-1:0] next_trgSync;
  logic [NCH-1:0] next_trgPrev;

  always_comb
  begin
    next_enMeta  = enablePin;
    next_enSync  = enMeta;
    next_inhMeta = inhibitClosedPin;
    next_inhSync = inhMeta;
    next_trgMeta = triggerPin;
    next_trgSync = trgMeta;
    next_trgPrev = trgSync;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      enMeta  <= '0;
      enSync  <= '0;
      inhMeta <= '0;
      inhSync <= '0;
      trgMeta <= '0;
      trgSync <= '0;
      trgPrev <= '0;
    end
    else
    begin
      enMeta  <= next_enMeta;
      enSync  <= next_enSync;
      inhMeta <= next_inhMeta;
      inhSync <= next_inhSync;
      trgMeta <= next_trgMeta;
      trgSync <= next_trgSync;
      trgPrev <= next_trgPrev;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0]    irqStat;
  logic [31:0]    irqMask;
  logic [31:0]    next_irqStat;
  logic [31:0]    next_irqMask;
  logic [31:0]    next_readdata;
  logic           next_waitrequest;
  logic [NCH-1:0] onCmd;
  logic [NCH-1:0] latched;
  logic           wrDone;

  // Every access answers one cycle after it appears
  assign wrDone = avs_write && !avs_waitrequest;

  always_comb
  begin
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata    = avs_readdata;
    onCmd            = '0;
    if (wrDone && avs_address == REG_CTRL)
    begin
      onCmd = avs_writedata[NCH-1:0];
    end
    if (avs_read && avs_waitrequest)
    begin
      next_readdata = 32'h0000_0000;
      if (avs_address == REG_STATUS)
      begin
        next_readdata[ST_ON_POS +: NCH]    = outputOn;
        next_readdata[ST_LATCH_POS +: NCH] = latched;
        next_readdata[ST_CC_POS +: NCH]    = regulation_mode_indicator;
        next_readdata[ST_FAULT_POS +: NCH] = faultInd;
      end
      else if (avs_address == REG_IRQ_STAT)
      begin
        next_readdata = irqStat;
      end
      else if (avs_address == REG_IRQ_MASK)
      begin
        next_readdata = irqMask;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // ****************************************
  // Output control and sync pulse
  // ****************************************
  logic [PULSE_CNT_W-1:0] pulseCnt [NCH];
  logic [PULSE_CNT_W-1:0] next_pulseCnt [NCH];
  logic [NCH-1:0]         next_outputOn;
  logic [NCH-1:0]         next_latched;
  logic [NCH-1:0]         next_rampStart;
  logic [NCH-1:0]         next_syncPulse;
  logic [NCH-1:0]         trigRise;
  logic                   faultRise;

  always_comb
  begin
    trigRise       = trgSync & ~trgPrev;
    next_rampStart = trigRise;
    // trip latches; open contact outweighs a same-cycle on command
    next_latched   = (latched & ~onCmd) | ~inhSync;
    // enable gated by contact and latch
    next_outputOn  = enSync & inhSync & ~next_latched;
    for (int i = 0; i < NCH; i++)
    begin
      next_pulseCnt[i] = pulseCnt[i];
      if (next_outputOn[i] != outputOn[i])
      begin
        next_pulseCnt[i] = PULSE_CNT_W'(PULSE_CYCLES);
      end
      else if (pulseCnt[i] != '0)
      begin
        next_pulseCnt[i] = pulseCnt[i] - PULSE_CNT_W'(1);
      end
      next_syncPulse[i] = next_pulseCnt[i] != '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // Power-up counts as latched so the output waits for a deliberate on command
      latched      <= '1;
      outputOn     <= '0;
      rampStart    <= '0;
      syncPulseOut <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        pulseCnt[i] <= '0;
      end
    end
    else
    begin
      latched      <= next_latched;
      outputOn     <= next_outputOn;
      rampStart    <= next_rampStart;
      syncPulseOut <= next_syncPulse;
      for (int i = 0; i < NCH; i++)
      begin
        pulseCnt[i] <= next_pulseCnt[i];
      end
    end
  end

  // ****************************************
  // Status lines and interrupts
  // ****************************************
  logic [NCH-1:0] next_regMode;
  logic [NCH-1:0] next_outState;
  logic [NCH-1:0] next_faultInd;
  logic [31:0]    events;
  logic           next_irq;

  always_comb
  begin
    next_regMode  = ccMode;
    next_outState = next_outputOn;
    next_faultInd = faultState;
    faultRise     = |(faultState & ~faultInd);
    events        = 32'h0000_0000;
    events[IRQ_TRIP_POS +: NCH] = ~inhSync & ~latched;
    events[IRQ_TRIG_POS +: NCH] = trigRise;
    events[IRQ_FAULT_POS]       = faultRise;
    next_irqMask  = irqMask;
    next_irqStat  = irqStat;
    if (wrDone && avs_address == REG_IRQ_MASK)
    begin
      next_irqMask = avs_writedata;
    end
    if (wrDone && avs_address == REG_IRQ_STAT)
    begin
      next_irqStat = irqStat & ~avs_writedata;
    end
    // New events win over a same-cycle clear
    next_irqStat = next_irqStat | events;
    next_irq     = |(next_irqStat & next_irqMask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      regulation_mode_indicator <= '0;
      outStateInd               <= '0;
      faultInd                  <= '0;
      irqStat                   <= 32'h0000_0000;
      irqMask                   <= IRQ_MASK_RST;
      irq                       <= 1'b0;
    end
    else
    begin
      regulation_mode_indicator <= next_regMode;
      outStateInd               <= next_outState;
      faultInd                  <= next_faultInd;
      irqStat                   <= next_irqStat;
      irqMask                   <= next_irqMask;
      irq                       <= next_irq;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // enable low forces off
  a_enable_off: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (outputOn & ~$past(enSync)) == '0)
    else $error("output on while enable low");

  // enable high with contact closed and no latch turns on
  a_enable_on: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> ((($past(enSync) & $past(inhSync) & ~latched) & ~outputOn) == '0))
    else $error("output off while enabled");

  a_inhibit_off: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (outputOn & ~$past(inhSync)) == '0)
    else $error("output on while inhibit open");

  a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $past(onCmd) == '0 |-> (($past(latched) & ~latched) == '0))
    else $error("latch cleared without on command");

  a_latch_set: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (~$past(inhSync) & ~latched) == '0)
    else $error("trip not latched");

  // rising trigger starts ramp one cycle later
  a_trig_start: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> rampStart == ($past(trgSync) & ~$past(trgPrev)))
    else $error("ramp start mismatch");

  a_sync_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    outputOn != $past(outputOn) |-> (syncPulseOut & (outputOn ^ $past(outputOn)))
      == (outputOn ^ $past(outputOn)))
    else $error("no sync pulse on change");

  // pulse ends exactly when count runs out
  a_sync_len: assert property (@(posedge clk_sys) disable iff (rst)
    pulseCnt[0] == PULSE_CNT_W'(1) && outputOn[0] == $past(outputOn[0])
      |=> (outputOn[0] != $past(outputOn[0])) || !syncPulseOut[0])
    else $error("sync pulse length wrong");

  a_status_follow: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> regulation_mode_indicator == $past(ccMode) && faultInd == $past(faultState))
    else $error("indicator lag wrong");

  a_state_ind: assert property (@(posedge clk_sys) disable iff (rst)
    outStateInd == outputOn)
    else $error("state indicator mismatch");

endmodule
`default_nettype wire

// *** verilog/rmio_pkg.sv ***
// Constants shared by the remote user control block
`default_nettype none
package rmio_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT  = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK  = 4'hC;
  // Event field positions inside the interrupt registers
  localparam int IRQ_TRIP_POS  = 0;
  localparam int IRQ_TRIG_POS  = 4;
  localparam int IRQ_FAULT_POS = 8;
  // Status field positions
  localparam int ST_ON_POS     = 0;
  localparam int ST_LATCH_POS  = 4;
  localparam int ST_CC_POS     = 8;
  localparam int ST_FAULT_POS  = 12;
  // Reset values
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  // Sync pulse timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int PULSE_MS      = 10;
  localparam int PULSE_CYC     = PULSE_MS * (CLK_HZ / 1000);
  localparam int PULSE_CNT_W   = 18;
endpackage
`default_nettype wire

// *** bench/rmio_ctrl_model.sv ***
// Outside controller model driving the remote enable, inhibit and trigger pins
`default_nettype none
module rmio_ctrl_model
#(
  parameter int NCH = 3
)(
  input  wire logic           clk_sys,
  input  wire logic [NCH-1:0] wantEnable,
  input  wire logic [NCH-1:0] wantClosed,
  input  wire logic [NCH-1:0] wantTrigger,
  output logic      [NCH-1:0] enablePin,
  output logic      [NCH-1:0] inhibitClosedPin,
  output logic      [NCH-1:0] triggerPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // contact held as outside party sets it
  always_ff @(posedge clk_sys)
  begin
    enablePin        <= wantEnable;
    inhibitClosedPin <= wantClosed;
    triggerPin       <= wantTrigger;
  end
endmodule
`default_nettype wire

// *** bench/rmio_top_bench.sv ***
// Self-checking bench for the remote control pin block
`default_nettype none
module rmio_top_bench
  import rmio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 20;
  logic        clk_sys, rst, avsRead, avsWrite, irq, avs_waitrequest;
  logic [3:0]  avsAddress;
  logic [31:0] avsWritedata, avs_readdata, d;
  logic [2:0]  wEn, wCl, wTr, en, cl, tr, ccMode, faultState;
  logic [2:0]  outputOn, rampStart, syncPulseOut, regInd, outStateInd, faultInd;
  logic [2:0]  prevF;
  logic        fr;
  int          failCount, checksDone, n;
  rmio_ctrl_model #(.NCH(3)) partner (.clk_sys(clk_sys), .wantEnable(wEn), .wantClosed(wCl),
    .wantTrigger(wTr), .enablePin(en), .inhibitClosedPin(cl), .triggerPin(tr));
  rmio_top #(.NCH(3), .PULSE_CYCLES(PC)) uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enablePin(en), .inhibitClosedPin(cl), .triggerPin(tr),
    .ccMode(ccMode), .faultState(faultState), .outputOn(outputOn), .rampStart(rampStart),
    .syncPulseOut(syncPulseOut), .regulation_mode_indicator(regInd), .outStateInd(outStateInd),
    .faultInd(faultInd), .irq(irq));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] stat(logic [2:0] o, l, c, f);
    return {16'h0000, 1'b0, f, 1'b0, c, 1'b0, l, 1'b0, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (failCount == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= wd;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // ****
  // Clock, watchdog and tests
  // ****
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    cyc(20000);
    failCount++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(17681));
    rst = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWritedata} = '0;
    {wEn, wTr, ccMode, faultState} = '0;
    wCl = 3'h7;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    chk("outOnReset", outputOn, 3'h0);
    bus(REG_STATUS, 1'b0, 32'h0000_0000, d);
    chk("statReset", d, stat(3'h0, 3'h7, 3'h0, 3'h0));
    wEn <= 3'h7;
    cyc(6);
    chk("latchedOff", outputOn, 3'h0);
    n = 0;
    // Count alongside the write: the pulse starts before the bus task returns
    fork
      bus(REG_CTRL, 1'b1, 32'h0000_0007, d);
      repeat (PC + 24)
      begin
        @(posedge clk_sys);
        n += syncPulseOut[0];
      end
    join
    chk("pulseLen", n, PC);
    chk("outOn", outputOn, 3'h7);
    chk("stateInd", outStateInd, 3'h7);
    bus(REG_IRQ_MASK, 1'b1, 32'h0000_01FF, d);
    wCl <= 3'h6;
    cyc(6);
    chk("tripOff", outputOn, 3'h6);
    bus(REG_IRQ_STAT, 1'b0, 32'h0000_0000, d);
    chk("tripIrqStat", d, 32'h0000_0001);
    chk("irqHigh", irq, 1'b1);
    wCl <= 3'h7;
    cyc(6);
    chk("staysOff", outputOn, 3'h6);
    bus(REG_IRQ_STAT, 1'b1, 32'h0000_0001, d);
    cyc(2);
    chk("irqClear", irq, 1'b0);
    bus(REG_CTRL, 1'b1, 32'h0000_0001, d);
    cyc(6);
    chk("reOn", outputOn, 3'h7);
    wEn <= 3'h5;
    cyc(6);
    chk("enLow", outputOn, 3'h5);
    chk("stateInd2", outStateInd, 3'h5);
    wTr <= 3'h4;
    n = 0;
    repeat (12)
    begin
      @(posedge clk_sys);
      n += rampStart[2];
    end
    wTr <= 3'h0;
    chk("rampOnce", n, 1);
    bus(REG_IRQ_STAT, 1'b0, 32'h0000_0000, d);
    chk("trigIrqStat", d, 32'h0000_0040);
    bus(REG_IRQ_STAT, 1'b1, 32'h0000_01FF, d);
    prevF = 3'h0;
    fr    = 1'b0;
    repeat (40)
    begin
      d = $urandom;
      ccMode     <= d[2:0];
      faultState <= d[5:3];
      fr         = fr | (|(d[5:3] & ~prevF));
      prevF      = d[5:3];
      cyc(3);
      chk("ccInd", regInd, ccMode);
      chk("faultInd", faultInd, faultState);
    end
    bus(REG_IRQ_STAT, 1'b0, 32'h0000_0000, d);
    chk("faultIrqStat", d, {23'h000000, fr, 8'h00});
    chk("faultIrq", irq, fr);
    bus(REG_STATUS, 1'b0, 32'h0000_0000, d);
    chk("statEnd", d, stat(3'h5, 3'h0, ccMode, faultState));
    bus(4'h2, 1'b0, 32'h0000_0000, d);
    chk("unmapped", d, 32'h0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
